// ==== logic/pbw_pkg.sv ====
// package: register map, field positions and burst decoders
package pbw_pkg;
  localparam int COL_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [7:0] CFG_OFF = 8'h00;
  localparam logic [7:0] CMD_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [7:0] WCNT_OFF = 8'h0C;
  localparam logic [7:0] SCNT_OFF = 8'h10;
  localparam logic [15:0] CFG_RESET = 16'h9D1F;
  localparam logic [15:0] CFG_WMASK = 16'hFD3F;
  localparam int BL_LO = 0;
  localparam int WRAP_BIT = 3;
  localparam int DRV_LO = 4;
  localparam int WCFG_BIT = 8;
  localparam int POL_BIT = 10;
  localparam int CMD_DIR_BIT = 8;
  localparam logic [1:0] DRV_RSVD = 2'h3;
  localparam logic [2:0] BL4 = 3'h1;
  localparam logic [2:0] BL8 = 3'h2;
  localparam logic [2:0] BL16 = 3'h3;
  localparam logic [2:0] BL32 = 3'h4;

  // words per burst; zero means run to the end of the row
  function automatic logic [5:0] pbw_bl_words(input logic [2:0] code);
    case (code)
      BL4: return 6'h04;
      BL8: return 6'h08;
      BL16: return 6'h10;
      BL32: return 6'h20;
      default: return 6'h00;
    endcase
  endfunction
endpackage

// ==== logic/pbw_seq_if.sv ====
// interface: sequencer, wait timing and control between modules
`timescale 1ns/1ps
interface pbw_seq_if #(parameter int COL_W = 8)
(
  input wire logic pclk,
  input wire logic presetn
);
  logic start;
  logic [COL_W-1:0] start_col;
  logic [2:0] bl_code;
  logic nowrap;
  logic stall;
  logic issue;
  logic busy;
  logic [COL_W-1:0] col;
  logic wcfg;
  logic pol;
  logic word_valid;
  logic [COL_W-1:0] word_col;
  logic wait_pin;
  modport seq (input pclk, presetn, start, start_col, bl_code, nowrap,
    stall, output issue, busy, col);
  modport tmg (input pclk, presetn, issue, col, wcfg, pol,
    output word_valid, word_col, wait_pin);
  modport ctl (output start, start_col, bl_code, nowrap, stall, wcfg,
    pol, input issue, busy, col, word_valid, word_col, wait_pin);
endinterface

// ==== logic/pbw_burst_seq.sv ====
// burst word-order generator: wrapping or linear to row end
`timescale 1ns/1ps
module pbw_burst_seq #(parameter int COL_W = 8)
(
  pbw_seq_if.seq sif
);
  import pbw_pkg::*;
  localparam int CNT_W = COL_W + 1;
  if (COL_W < 5)
  begin : g_bad_width
    $error("pbw_burst_seq: row too short for 32-word bursts");
  end
  typedef struct packed {
    logic busy;
    logic lin;
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] col;
    logic [CNT_W-1:0] left;
  } pbw_seq_st_t;
  pbw_seq_st_t s;
  pbw_seq_st_t next_s;
  logic [CNT_W-1:0] words;
  logic [CNT_W-1:0] row_left;

  // burst mode is latched at start, so a config write mid-burst is safe
  always_comb
  begin
    words = CNT_W'(pbw_bl_words(sif.bl_code));
    row_left = CNT_W'(2 ** COL_W) - {1'b0, sif.start_col};
    next_s = s;
    if (s.busy && !sif.stall)
    begin
      if (s.lin)
        next_s.col = s.col + 1'b1;
      else
        next_s.col = (s.col & ~s.mask) | ((s.col + 1'b1) & s.mask);
      next_s.left = s.left - 1'b1;
      next_s.busy = (s.left != CNT_W'(1));
    end
    else if (!s.busy && sif.start)
    begin
      next_s.busy = 1'b1;
      next_s.col = sif.start_col;
      next_s.lin = sif.nowrap || (words == '0);
      next_s.mask = COL_W'(words - 1'b1);
      if (words == '0 || (sif.nowrap && row_left < words))
        next_s.left = row_left;
      else
        next_s.left = words;
    end
  end

  always_ff @(posedge sif.pclk or negedge sif.presetn)
  begin
    if (!sif.presetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign sif.issue = s.busy & ~sif.stall;
  assign sif.busy = s.busy;
  assign sif.col = s.col;

  property p_wrap_block;
    @(posedge sif.pclk) disable iff (!sif.presetn)
    sif.issue && !s.lin |=> ((sif.col ^ $past(sif.col)) & ~s.mask) == '0;
  endproperty
  a_wrap_block: assert property (p_wrap_block)
    else $error("wrapped burst left its aligned block");
  property p_linear_step;
    @(posedge sif.pclk) disable iff (!sif.presetn)
    sif.issue && s.lin |=> sif.col == $past(sif.col) + 1'b1;
  endproperty
  a_linear_step: assert property (p_linear_step)
    else $error("linear burst did not step by one");
  property p_row_end;
    @(posedge sif.pclk) disable iff (!sif.presetn)
    sif.issue && s.lin && (s.col == '1) |=> !sif.busy;
  endproperty
  a_row_end: assert property (p_row_end)
    else $error("linear burst crossed the end of the row");
endmodule

// ==== logic/pbw_wait_tmg.sv ====
// data-valid pipeline and wait pin timing and polarity
`timescale 1ns/1ps
module pbw_wait_tmg #(parameter int COL_W = 8)
(
  pbw_seq_if.tmg tif
);
  typedef struct packed {
    logic p_valid;
    logic [COL_W-1:0] p_col;
    logic w_valid;
    logic [COL_W-1:0] w_col;
    logic wait_pin;
  } pbw_tmg_st_t;
  localparam pbw_tmg_st_t TMG_RST = '{wait_pin: 1'b1, default: '0};
  pbw_tmg_st_t s;
  pbw_tmg_st_t next_s;
  logic asrt;

  // one staging register gives the early wait its clock of lead
  always_comb
  begin
    next_s.p_valid = tif.issue;
    next_s.p_col = tif.col;
    next_s.w_valid = s.p_valid;
    next_s.w_col = s.p_col;
    asrt = tif.wcfg ? !tif.issue : !s.p_valid;
    next_s.wait_pin = tif.pol ? asrt : !asrt;
  end

  always_ff @(posedge tif.pclk or negedge tif.presetn)
  begin
    if (!tif.presetn)
      s <= TMG_RST;
    else
      s <= next_s;
  end

  assign tif.word_valid = s.w_valid;
  assign tif.word_col = s.w_col;
  assign tif.wait_pin = s.wait_pin;

  sequence s_lead_steady;
    tif.wcfg && $stable(tif.wcfg) && $stable(tif.pol);
  endsequence
  sequence s_late_steady;
    !tif.wcfg && $stable(tif.wcfg) && $stable(tif.pol);
  endsequence
  property p_wait_lead;
    @(posedge tif.pclk) disable iff (!tif.presetn)
    s_lead_steady |=>
      tif.word_valid == ($past(tif.wait_pin) != $past(tif.pol));
  endproperty
  a_wait_lead: assert property (p_wait_lead)
    else $error("early wait did not lead data by one clock");
  property p_wait_late;
    @(posedge tif.pclk) disable iff (!tif.presetn)
    s_late_steady |-> tif.word_valid == (tif.wait_pin != tif.pol);
  endproperty
  a_wait_late: assert property (p_wait_late)
    else $error("wait not aligned with valid data");
endmodule

// ==== logic/pbw_burst_wait_ctrl.sv ====
// top: apb registers, refresh sync, burst sequencer and wait timing
//
// Behaviour
// - wrap mode cycles addresses inside the aligned burst-length block
// - no-wrap mode steps linearly for the burst length, stopping early at the row's last word
// - wrap control comes up as no-wrap after reset
// - drive field: 00 full, 01 half, 10 quarter; 11 never taken
// - drive field comes up as half drive after reset
// - wait clear: wait changes at the same edge as data goes valid/invalid
// - wait set: wait changes one full clock before data does
// - wait timing comes up in the one-clock-early setting
// - a polarity bit picks whether asserted wait is high or low
// - wait polarity comes up active high
// - polarity 0 means active low, polarity 1 means active high
// - wrap and length act identically for read and write bursts
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module pbw_burst_wait_ctrl #(parameter int COL_W = pbw_pkg::COL_W)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pbw_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic refresh_hold,
  output logic wait_pin,
  output logic word_valid,
  output logic [COL_W-1:0] word_col,
  output logic burst_write,
  output logic [1:0] drive_sel
);
  import pbw_pkg::*;

  if (COL_W < 5 || COL_W > 24)
  begin : g_bad_width
    $error("pbw_burst_wait_ctrl: COL_W must lie in 5..24");
  end

  typedef struct packed {
    logic [15:0] cfg;
    logic [1:0] sync;
    logic start;
    logic [COL_W-1:0] start_col;
    logic dir;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] wcnt;
    logic [15:0] scnt;
  } pbw_top_st_t;
  localparam pbw_top_st_t TOP_RST = '{cfg: CFG_RESET, default: '0};

  pbw_top_st_t s;
  pbw_top_st_t next_s;
  logic setup;
  logic acc;
  logic [4:0] sel;
  logic [15:0] new_cfg;
  logic [31:0] stat;
  logic stall_ev;

  pbw_seq_if #(.COL_W(COL_W)) sif (
    .pclk(pclk),
    .presetn(presetn)
  );

  pbw_burst_seq #(.COL_W(COL_W)) u_seq (
    .sif(sif)
  );

  pbw_wait_tmg #(.COL_W(COL_W)) u_tmg (
    .tif(sif)
  );

  // one-hot register select; unmapped gives all zeros
  function automatic logic [4:0] reg_dec(
    input logic [ADDR_W-1:0] a
  );
    case (a)
      CFG_OFF: return 5'h01;
      CMD_OFF: return 5'h02;
      STAT_OFF: return 5'h04;
      WCNT_OFF: return 5'h08;
      SCNT_OFF: return 5'h10;
      default: return 5'h00;
    endcase
  endfunction

  // sequencer and timing see the live config, start fields from command
  assign sif.start = s.start;
  assign sif.start_col = s.start_col;
  assign sif.bl_code = s.cfg[BL_LO +: 3];
  assign sif.nowrap = s.cfg[WRAP_BIT];
  assign sif.stall = s.sync[1];
  assign sif.wcfg = s.cfg[WCFG_BIT];
  assign sif.pol = s.cfg[POL_BIT];

  always_comb
  begin
    setup = psel && !penable;
    acc = psel && penable && s.pready;
    sel = reg_dec(paddr);
    stall_ev = sif.busy && s.sync[1];
    stat = '0;
    stat[0] = sif.busy;
    stat[1] = s.dir;
    stat[2] = s.sync[1];
    stat[3] = sif.word_valid;
    stat[8 +: COL_W] = sif.col;
    new_cfg = (s.cfg & ~CFG_WMASK) | (pwdata[15:0] & CFG_WMASK);
    // a reserved drive code leaves the old strength in place
    if (new_cfg[DRV_LO +: 2] == DRV_RSVD)
      new_cfg[DRV_LO +: 2] = s.cfg[DRV_LO +: 2];
    next_s = s;
    // refresh collision pin is asynchronous to pclk
    next_s.sync = {s.sync[0], refresh_hold};
    next_s.start = 1'b0;
    // word and stall counters; an event in the clearing cycle still counts
    next_s.wcnt = s.wcnt + {15'h0000, sif.word_valid};
    next_s.scnt = s.scnt + {15'h0000, stall_ev};
    if (setup)
    begin
      next_s.pready = 1'b1;
      next_s.pslverr = (sel == 5'h00);
      next_s.prdata = '0;
      if (!pwrite)
      begin
        unique case (1'b1)
          sel[0]: next_s.prdata = {16'h0000, s.cfg};
          sel[2]: next_s.prdata = stat;
          sel[3]: next_s.prdata = {16'h0000, s.wcnt};
          sel[4]: next_s.prdata = {16'h0000, s.scnt};
          default: next_s.prdata = '0;
        endcase
      end
    end
    if (acc)
    begin
      next_s.pready = 1'b0;
      if (pwrite)
      begin
        if (sel[0])
          next_s.cfg = new_cfg;
        // a command while a burst runs is dropped without error
        if (sel[1] && !sif.busy && !s.start)
        begin
          next_s.start = 1'b1;
          next_s.start_col = pwdata[COL_W-1:0];
          next_s.dir = pwdata[CMD_DIR_BIT];
        end
        if (sel[3])
          next_s.wcnt = {15'h0000, sif.word_valid};
        if (sel[4])
          next_s.scnt = {15'h0000, stall_ev};
      end
    end
  end

  // reset value brings no-wrap, half drive, early wait, active-high wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= TOP_RST;
    else
      s <= next_s;
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign wait_pin = sif.wait_pin;
  assign word_valid = sif.word_valid;
  assign word_col = sif.word_col;
  assign burst_write = s.dir;
  assign drive_sel = s.cfg[DRV_LO +: 2];

  property p_cfg_rst;
    @(posedge pclk)
    $rose(presetn) |-> s.cfg[WRAP_BIT] && s.cfg[WCFG_BIT] &&
      s.cfg[POL_BIT] && (s.cfg[DRV_LO +: 2] == 2'h1);
  endproperty
  a_cfg_rst: assert property (p_cfg_rst)
    else $error("config did not come up at its reset value");

  property p_drive_legal;
    @(posedge pclk) disable iff (!presetn)
    drive_sel != DRV_RSVD;
  endproperty
  a_drive_legal: assert property (p_drive_legal)
    else $error("reserved drive strength code selected");

  sequence s_apb_setup;
    psel && !penable;
  endsequence
  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
    s_apb_setup |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer not a single access cycle");

  sequence s_cmd_taken;
    acc && pwrite && sel[1] && !sif.busy && !s.start;
  endsequence
  property p_cmd_start;
    @(posedge pclk) disable iff (!presetn)
    s_cmd_taken |=> s.start ##1 sif.busy;
  endproperty
  a_cmd_start: assert property (p_cmd_start)
    else $error("accepted command did not start a burst");

  property p_err_unmapped;
    @(posedge pclk) disable iff (!presetn)
    setup && (sel == 5'h00) |=> pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("unmapped address gave no slave error");

  property p_ok_mapped;
    @(posedge pclk) disable iff (!presetn)
    setup && (sel != 5'h00) |=> !pslverr;
  endproperty
  a_ok_mapped: assert property (p_ok_mapped)
    else $error("mapped address gave a slave error");

  property p_err_rdata;
    @(posedge pclk) disable iff (!presetn)
    pready && pslverr |-> prdata == '0;
  endproperty
  a_err_rdata: assert property (p_err_rdata)
    else $error("errored access returned nonzero data");

  property p_cfg_hold;
    @(posedge pclk) disable iff (!presetn)
    !(acc && pwrite && sel[0]) |=> $stable(s.cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("config changed without a config write");

  property p_drive_write;
    @(posedge pclk) disable iff (!presetn)
    acc && pwrite && sel[0] && (pwdata[DRV_LO +: 2] != DRV_RSVD) |=>
      drive_sel == $past(pwdata[DRV_LO +: 2]);
  endproperty
  a_drive_write: assert property (p_drive_write)
    else $error("legal drive code not taken");

  property p_drive_kept;
    @(posedge pclk) disable iff (!presetn)
    acc && pwrite && sel[0] && (pwdata[DRV_LO +: 2] == DRV_RSVD) |=>
      $stable(drive_sel);
  endproperty
  a_drive_kept: assert property (p_drive_kept)
    else $error("reserved drive code changed the strength");

  property p_wrap_write;
    @(posedge pclk) disable iff (!presetn)
    acc && pwrite && sel[0] |=> sif.nowrap == $past(pwdata[WRAP_BIT]);
  endproperty
  a_wrap_write: assert property (p_wrap_write)
    else $error("wrap control not taken from config write");

  property p_cmd_dropped;
    @(posedge pclk) disable iff (!presetn)
    acc && pwrite && sel[1] && sif.busy |=> !s.start;
  endproperty
  a_cmd_dropped: assert property (p_cmd_dropped)
    else $error("command accepted while a burst ran");

  property p_dir_with_start;
    @(posedge pclk) disable iff (!presetn)
    $changed(burst_write) |-> s.start;
  endproperty
  a_dir_with_start: assert property (p_dir_with_start)
    else $error("direction changed without a command");

  property p_busy_from_start;
    @(posedge pclk) disable iff (!presetn)
    $rose(sif.busy) |-> $past(s.start);
  endproperty
  a_busy_from_start: assert property (p_busy_from_start)
    else $error("burst began without a start pulse");

  property p_stall_col;
    @(posedge pclk) disable iff (!presetn)
    sif.busy && sif.stall |=> $stable(sif.col);
  endproperty
  a_stall_col: assert property (p_stall_col)
    else $error("column advanced during a refresh stall");

  property p_stall_early;
    @(posedge pclk) disable iff (!presetn)
    sif.stall && sif.busy && sif.wcfg |=> wait_pin == $past(sif.pol);
  endproperty
  a_stall_early: assert property (p_stall_early)
    else $error("early wait not asserted for a stall");

  // late wait needs the stage after the stall, so the setting must hold
  sequence s_stall_late;
    sif.stall && sif.busy && !sif.wcfg ##1 !sif.wcfg;
  endsequence
  property p_stall_late;
    @(posedge pclk) disable iff (!presetn)
    s_stall_late |=> wait_pin == $past(sif.pol);
  endproperty
  a_stall_late: assert property (p_stall_late)
    else $error("late wait not asserted for a stall");

  property p_word_pipe;
    @(posedge pclk) disable iff (!presetn)
    sif.issue |-> ##2 word_valid && (word_col == $past(sif.col, 2));
  endproperty
  a_word_pipe: assert property (p_word_pipe)
    else $error("issued word not on the bus two clocks later");

  property p_idle_no_word;
    @(posedge pclk) disable iff (!presetn)
    !sif.busy |-> ##2 !word_valid;
  endproperty
  a_idle_no_word: assert property (p_idle_no_word)
    else $error("word shown valid while no burst ran");

  property p_wcnt_step;
    @(posedge pclk) disable iff (!presetn)
    word_valid && !(acc && pwrite && sel[3]) |=>
      s.wcnt == $past(s.wcnt) + 16'h0001;
  endproperty
  a_wcnt_step: assert property (p_wcnt_step)
    else $error("word counter missed a valid word");

  property p_wcnt_clear;
    @(posedge pclk) disable iff (!presetn)
    acc && pwrite && sel[3] |=> s.wcnt == {15'h0000, $past(word_valid)};
  endproperty
  a_wcnt_clear: assert property (p_wcnt_clear)
    else $error("word counter clear lost its event");

  property p_stat_busy;
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && sel[2] |=> prdata[0] == $past(sif.busy);
  endproperty
  a_stat_busy: assert property (p_stat_busy)
    else $error("status read did not show the busy flag");
endmodule

// ==== sim/pbw_host_model.sv ====
// partner: burst bus controller that moves words only while wait says valid
`timescale 1ns/1ps
module pbw_host_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wait_pin,
  input wire logic word_valid,
  input wire logic [7:0] word_col,
  input wire logic pol,
  input wire logic early,
  input wire logic arm,
  input wire logic hold_req,
  output logic refresh_hold
);
  logic deas;
  logic deas_q;
  logic take;
  logic [7:0] cols[$];
  int err = 0;
  // deasserted means the level opposite to the chosen polarity
  assign deas = wait_pin ^ pol;
  // early setting: data follows the wait change by one clock
  assign take = early ? deas_q : deas;
  assign refresh_hold = hold_req;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      deas_q <= 1'b0;
    else
      deas_q <= deas;
  end
  // only judged while armed, so config changes between bursts never count
  always @(posedge pclk)
  begin
    if (presetn && arm)
    begin
      if (take !== word_valid)
        err++;
      if (take)
        cols.push_back(word_col);
    end
  end
endmodule

// ==== sim/tb_top.sv ====
// testbench: apb-driven burst scenarios checked through the host model
`timescale 1ns/1ps
module tb_top;
  import pbw_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, wait_pin, word_valid, burst_write, refresh_hold;
  logic [7:0] word_col;
  logic [1:0] drive_sel;
  logic pol = 1'b1;
  logic early = 1'b1;
  logic arm = 1'b0;
  logic hold_req = 1'b0;
  int mismatches = 0;
  int check_count = 0;
  logic [2:0] bls [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h4, 3'h7, 3'h5};
  int sts [8] = '{6, 14, 254, 255, 254, 15, 250, 252};
  logic [7:0] nwv = 8'hB0;

  initial forever #50 pclk = ~pclk;

  pbw_burst_wait_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .refresh_hold(refresh_hold), .wait_pin(wait_pin),
    .word_valid(word_valid), .word_col(word_col),
    .burst_write(burst_write), .drive_sel(drive_sel));

  pbw_host_model i_host (.pclk(pclk), .presetn(presetn),
    .wait_pin(wait_pin), .word_valid(word_valid), .word_col(word_col),
    .pol(pol), .early(early), .arm(arm), .hold_req(hold_req),
    .refresh_hold(refresh_hold));

  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  // request held from setup until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      mismatches++;
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  function automatic logic [31:0] exp_col(int s, int n, logic lin, int i);
    if (lin)
      return s + i;
    return (s & ~(n - 1)) | ((s + i) & (n - 1));
  endfunction

  initial
  begin
    repeat (40000) @(posedge pclk);
    mismatches++;
    print_verdict();
  end

  initial
  begin
    logic [31:0] q;
    logic e;
    logic [15:0] cfg;
    logic lin;
    int n;
    int st;
    int m;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk("wait idle", 32'h1, wait_pin);
    chk("drive", 32'h1, drive_sel);
    rd(CFG_OFF, q);
    chk("cfg reset", 32'h9D1F, q);
    for (int k = 0; k < 8; k++)
    begin
      st = sts[k];
      cfg = {5'h13, k[0], 1'b0, k[1], 2'h0, 2'(k % 3), nwv[k], bls[k]};
      wr(CFG_OFF, {16'h0, cfg});
      rd(CFG_OFF, q);
      chk("cfg", {16'h0, cfg}, q);
      chk("drive", k % 3, drive_sel);
      chk("wait idle", k[0], wait_pin);
      pol <= k[0];
      early <= k[1];
      // reserved length codes and continuous run linearly to the row end
      lin = nwv[k] || bls[k] < 1 || bls[k] > 4;
      n = (bls[k] >= 1 && bls[k] <= 4) ? (4 << (bls[k] - 1)) : 256 - st;
      if (lin && n > 256 - st)
        n = 256 - st;
      wr(WCNT_OFF, 32'h0);
      i_host.cols.delete();
      arm <= 1'b1;
      wr(CMD_OFF, {23'h0, k[2], 8'(st)});
      // busy rises two clocks after the command, so never poll sooner
      hold_req <= k[1];
      repeat (3) @(posedge pclk);
      hold_req <= 1'b0;
      m = 0;
      do
      begin
        rd(STAT_OFF, q);
        m++;
      end
      while (q[0] !== 1'b0 && m < 200);
      chk("busy", 32'h0, q[0]);
      // two pipeline stages trail the sequencer
      repeat (6) @(posedge pclk);
      arm <= 1'b0;
      chk("words", n, i_host.cols.size());
      for (int i = 0; i < n && i < i_host.cols.size(); i++)
        chk("col", exp_col(st, n, lin, i), i_host.cols[i]);
      chk("host", 32'h0, i_host.err);
      rd(WCNT_OFF, q);
      chk("wcnt", n, q);
      chk("dir", k[2], burst_write);
    end
    wr(CFG_OFF, 32'h9D3F);
    rd(CFG_OFF, q);
    chk("cfg rsvd drive", 32'h9D1F, q);
    chk("drive", 32'h1, drive_sel);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk("slverr", 32'h1, e);
    chk("unmapped", 32'h0, q);
    // four held scenarios, three synced stall clocks each
    rd(SCNT_OFF, q);
    chk("scnt", 32'h0000000C, q);
    print_verdict();
  end
endmodule
